//--- pkg/atsb_map.vh
// Function
// - Thirty-two tone generators with independent settings.
// - Setting changes reach every channel using source.
// - Mute replaces tone samples with zero samples.
// - Frequency 10 to 20000 Hz, half-hertz steps.
// - Amplitude -60 to 0 dB, 1 dB steps.
// - Click cycle 1-4 s, last 250 ms muted.
// - Click disabled gives continuous tone.
// - Four-character origin tag carried with samples.
`ifndef ATSB_MAP_VH
`define ATSB_MAP_VH
`define ATSB_NUM_SRC 32
`define ATSB_REG_CTRL 10'h000
`define ATSB_REG_STATUS 10'h004
`define ATSB_REG_SWEEPS 10'h008
`define ATSB_REG_SRC_BASE 10'h100
`define ATSB_REG_SRC_END 10'h300
`define ATSB_SRC_FREQ 2'h0
`define ATSB_SRC_CTRL 2'h1
`define ATSB_SRC_TAG 2'h2
`define ATSB_CTRL_RUN_BIT 0
`define ATSB_STAT_BUSY_BIT 0
`define ATSB_STAT_OVR_BIT 1
`define ATSB_STAT_LVL_LSB 8
`define ATSB_SC_ATT_LSB 0
`define ATSB_SC_MUTE_BIT 8
`define ATSB_SC_CLK_EN_BIT 9
`define ATSB_SC_CLK_SEL_LSB 10
`define ATSB_CTRL_RESET 1'b0
`define ATSB_FREQ_RESET 16'h07d0
`define ATSB_ATT_RESET 6'h14
`define ATSB_TAG_RESET 32'h20202020
`define ATSB_FREQ_MIN 16'h0014
`define ATSB_FREQ_MAX 16'h9c40
`define ATSB_ATT_MAX 6'h3c
`define ATSB_SAMPLE_RATE_HZ 48000
`define ATSB_CLICK_GAP_MS 250
`define ATSB_FIFO_DEPTH 16
`endif

//--- verilog/atsb_fifo.v
`timescale 1ns/10ps
`default_nettype none
module atsb_fifo #(
   parameter WIDTH = 61,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire ref_clk,
   input wire resetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire push;
   wire pop;
   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];
   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/atsb_bank.v
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "atsb_map.vh"
module atsb_bank #(
   parameter [17:0] SAMPLE_RATE_HZ = `ATSB_SAMPLE_RATE_HZ
) (
   input wire ref_clk,
   input wire resetn,
   input wire [9:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire sample_stb,
   output wire src_valid,
   input wire src_ready,
   output wire [4:0] src_index,
   output wire [23:0] src_sample,
   output wire [31:0] channel_origin_tag
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   localparam [47:0] PHASE_K = 48'h010000000000 / (48'd2 * SAMPLE_RATE_HZ);
   localparam integer GAP_COUNT = (SAMPLE_RATE_HZ * `ATSB_CLICK_GAP_MS) / 1000;
   localparam [17:0] GAP_SAMPLES = GAP_COUNT[17:0];
   localparam integer LAST_COUNT = `ATSB_NUM_SRC - 1;
   localparam [4:0] LAST_SRC = LAST_COUNT[4:0];

   reg [15:0] freq_set [0:`ATSB_NUM_SRC-1];
   reg [5:0] att_set [0:`ATSB_NUM_SRC-1];
   reg mute_set [0:`ATSB_NUM_SRC-1];
   reg click_en [0:`ATSB_NUM_SRC-1];
   reg [1:0] click_sel [0:`ATSB_NUM_SRC-1];
   reg [31:0] tag_set [0:`ATSB_NUM_SRC-1];
   reg [31:0] phase [0:`ATSB_NUM_SRC-1];
   reg [17:0] click_cnt [0:`ATSB_NUM_SRC-1];

   reg run_en;
   reg overrun;
   reg [31:0] sweeps;
   reg ack;
   reg [1:0] state;
   reg [4:0] idx;
   integer i;

   wire [9:0] rel;
   wire in_src;
   wire [4:0] reg_sel;
   wire [1:0] reg_fld;
   wire wr_take;
   wire fifo_ready;
   wire [4:0] fifo_level;
   wire push;
   reg [31:0] next_readdata;
   wire hit_ctrl;
   wire hit_status;
   wire hit_sweeps;
   wire src_rd_ok;

   function [31:0] bmerge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      begin
         bmerge = (old & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}) |
                  (wd & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
      end
   endfunction

   assign rel = avs_address - `ATSB_REG_SRC_BASE;
   assign in_src = (avs_address >= `ATSB_REG_SRC_BASE) && (avs_address < `ATSB_REG_SRC_END);
   assign reg_sel = rel[8:4];
   assign reg_fld = rel[3:2];
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_take = avs_write & ack;
   assign hit_ctrl = (avs_address == `ATSB_REG_CTRL);
   assign hit_status = (avs_address == `ATSB_REG_STATUS);
   assign hit_sweeps = (avs_address == `ATSB_REG_SWEEPS);
   assign src_rd_ok = in_src && (reg_fld != 2'h3);

   // One wait state per access: ack rises the cycle after the request and ends it.
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   // Settings store; bank reads them live on every sweep, so every consumer of a source sees the change.
   wire [31:0] cur_word;
   wire [31:0] new_word;
   wire [31:0] cur_ctrl;
   assign cur_ctrl = {20'h0, click_sel[reg_sel], click_en[reg_sel], mute_set[reg_sel], 2'b00, att_set[reg_sel]};
   assign cur_word = (reg_fld == `ATSB_SRC_FREQ) ? {16'h0, freq_set[reg_sel]} :
                     (reg_fld == `ATSB_SRC_CTRL) ? cur_ctrl : tag_set[reg_sel];
   assign new_word = bmerge(cur_word, avs_writedata, avs_byteenable);

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < `ATSB_NUM_SRC; i = i + 1) begin
            freq_set[i] <= `ATSB_FREQ_RESET;
            att_set[i] <= `ATSB_ATT_RESET;
            mute_set[i] <= 1'b0;
            click_en[i] <= 1'b0;
            click_sel[i] <= 2'b00;
            tag_set[i] <= `ATSB_TAG_RESET;
         end
      end else if (wr_take && in_src) begin
         if (reg_fld == `ATSB_SRC_FREQ) begin
            if (new_word[31:0] < {16'h0, `ATSB_FREQ_MIN}) begin
               freq_set[reg_sel] <= `ATSB_FREQ_MIN;
            end else if (new_word[31:0] > {16'h0, `ATSB_FREQ_MAX}) begin
               freq_set[reg_sel] <= `ATSB_FREQ_MAX;
            end else begin
               freq_set[reg_sel] <= new_word[15:0];
            end
         end else if (reg_fld == `ATSB_SRC_CTRL) begin
            if (new_word[`ATSB_SC_ATT_LSB+5:`ATSB_SC_ATT_LSB] > `ATSB_ATT_MAX) begin
               att_set[reg_sel] <= `ATSB_ATT_MAX;
            end else begin
               att_set[reg_sel] <= new_word[`ATSB_SC_ATT_LSB+5:`ATSB_SC_ATT_LSB];
            end
            mute_set[reg_sel] <= new_word[`ATSB_SC_MUTE_BIT];
            click_en[reg_sel] <= new_word[`ATSB_SC_CLK_EN_BIT];
            click_sel[reg_sel] <= new_word[`ATSB_SC_CLK_SEL_LSB+1:`ATSB_SC_CLK_SEL_LSB];
         end else if (reg_fld == `ATSB_SRC_TAG) begin
            tag_set[reg_sel] <= new_word;
         end
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         run_en <= `ATSB_CTRL_RESET;
      end else if (wr_take && hit_ctrl && avs_byteenable[0]) begin
         run_en <= avs_writedata[`ATSB_CTRL_RUN_BIT];
      end
   end

   // A strobe that lands while a sweep is still running is flagged; a new event beats a clear.
   wire ovr_event;
   wire ovr_clear;
   assign ovr_event = sample_stb & state[1];
   assign ovr_clear = wr_take && hit_status && avs_byteenable[0] &&
                      avs_writedata[`ATSB_STAT_OVR_BIT];
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         overrun <= 1'b0;
      end else if (ovr_event) begin
         overrun <= 1'b1;
      end else if (ovr_clear) begin
         overrun <= 1'b0;
      end
   end

   always @* begin
      next_readdata = 32'h0;
      if (hit_ctrl) begin
         next_readdata[`ATSB_CTRL_RUN_BIT] = run_en;
      end else if (hit_status) begin
         next_readdata[`ATSB_STAT_BUSY_BIT] = state[1];
         next_readdata[`ATSB_STAT_OVR_BIT] = overrun;
         next_readdata[`ATSB_STAT_LVL_LSB+4:`ATSB_STAT_LVL_LSB] = fifo_level;
      end else if (hit_sweeps) begin
         next_readdata = sweeps;
      end else if (src_rd_ok) begin
         next_readdata = cur_word;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_readdata;
      end
   end

   // Sample datapath for the source under idx.
   wire [31:0] ph;
   wire [55:0] inc_full;
   wire [14:0] x;
   wire [29:0] xx;
   wire [16:0] y;
   wire [31:0] cy;
   wire [16:0] c;
   wire [33:0] s_full;
   wire [16:0] s;
   wire [23:0] mag;
   reg [16:0] gain_a;
   reg [16:0] gain_b;
   wire [33:0] gain_full;
   wire [16:0] gain;
   wire [40:0] scaled_full;
   wire [23:0] scaled;
   wire [23:0] signed_smp;
   wire [17:0] cyc_len;
   wire in_gap;
   wire [17:0] cnt_inc;
   wire [23:0] out_smp;
   wire [4:0] att_lo;
   wire [5:0] att_cur;
   wire [31:0] next_phase;
   wire push_take;

   assign ph = phase[idx];
   assign inc_full = freq_set[idx] * PHASE_K[39:0];
   assign next_phase = ph + inc_full[39:8];
   // Parabolic sine: y is 4x(1-x) in Q15, shaped by 0.775 + 0.225y.
   assign x = ph[30:16];
   assign xx = x * (15'h7fff - x + 15'h1);
   assign y = xx[29:13];
   assign cy = y * 17'h1cd;
   assign c = 17'h6333 + cy[27:11];
   assign s_full = y * c;
   assign s = s_full[31:15];
   assign mag = s[15] ? 24'h7fffff : {s[14:0], 9'h0};

   // Attenuation splits into a coarse 20 dB step and a fine 1 dB step table.
   assign att_cur = att_set[idx];
   assign att_lo = (att_cur >= 6'd40) ? att_cur[4:0] - 5'd8 :
                   (att_cur >= 6'd20) ? att_cur[4:0] - 5'd20 : att_cur[4:0];
   always @* begin
      gain_a = 17'h10000;
      if (att_cur >= 6'd60) begin
         gain_a = 17'h00042;
      end else if (att_cur >= 6'd40) begin
         gain_a = 17'h0028f;
      end else if (att_cur >= 6'd20) begin
         gain_a = 17'h0199a;
      end
   end
   always @* begin
      case (att_lo)
         5'd1: gain_b = 17'h0e429;
         5'd2: gain_b = 17'h0cb59;
         5'd3: gain_b = 17'h0b53c;
         5'd4: gain_b = 17'h0a186;
         5'd5: gain_b = 17'h08ff6;
         5'd6: gain_b = 17'h0804e;
         5'd7: gain_b = 17'h0725a;
         5'd8: gain_b = 17'h065ea;
         5'd9: gain_b = 17'h05ad5;
         5'd10: gain_b = 17'h050f4;
         5'd11: gain_b = 17'h04827;
         5'd12: gain_b = 17'h0404e;
         5'd13: gain_b = 17'h03950;
         5'd14: gain_b = 17'h03314;
         5'd15: gain_b = 17'h02d86;
         5'd16: gain_b = 17'h02893;
         5'd17: gain_b = 17'h02429;
         5'd18: gain_b = 17'h0203a;
         5'd19: gain_b = 17'h01cb9;
         default: gain_b = 17'h10000;
      endcase
   end
   assign gain_full = gain_a * gain_b;
   assign gain = gain_full[32:16];
   assign scaled_full = mag * gain;
   assign scaled = scaled_full[39:16];
   assign signed_smp = ph[31] ? (~scaled + 24'h1) : scaled;

   // Click cycle counts samples; the gap is its last quarter second.
   assign cyc_len = SAMPLE_RATE_HZ * ({16'h0, click_sel[idx]} + 18'h1);
   assign cnt_inc = click_cnt[idx] + 18'h1;
   assign in_gap = click_en[idx] && (click_cnt[idx] >= cyc_len - GAP_SAMPLES);
   assign out_smp = (mute_set[idx] || in_gap) ? 24'h0 : signed_smp;

   // Sweep sequencer: each strobe taken in ST_IDLE with run set walks all sources once, stalling on a full FIFO.
   assign push = state[1];
   assign push_take = push & fifo_ready;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         idx <= 5'h0;
         sweeps <= 32'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (sample_stb && run_en) begin
                  state <= ST_RUN;
                  idx <= 5'h0;
                  sweeps <= sweeps + 32'h1;
               end
            end
            ST_RUN: begin
               if (fifo_ready) begin
                  if (idx == LAST_SRC) begin
                     state <= ST_IDLE;
                  end else begin
                     idx <= idx + 5'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < `ATSB_NUM_SRC; i = i + 1) begin
            phase[i] <= 32'h0;
            click_cnt[i] <= 18'h0;
         end
      end else if (push_take) begin
         phase[idx] <= next_phase;
         if (!click_en[idx] || cnt_inc >= cyc_len) begin
            click_cnt[idx] <= 18'h0;
         end else begin
            click_cnt[idx] <= cnt_inc;
         end
      end
   end

   // Each word names its source, so the mapper may copy one source into any number of channels.
   wire [60:0] fifo_out;
   wire [60:0] fifo_in;
   assign fifo_in = {idx, out_smp, tag_set[idx]};
   atsb_fifo #(
      .WIDTH(61),
      .DEPTH(`ATSB_FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(fifo_in),
      .out_valid(src_valid),
      .out_ready(src_ready),
      .out_data(fifo_out),
      .level(fifo_level)
   );
   assign src_index = fifo_out[60:56];
   assign src_sample = fifo_out[55:32];
   assign channel_origin_tag = fifo_out[31:0];
endmodule
`default_nettype wire

//--- tb/atsb_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none
module atsb_bank_properties (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sample_stb,
   input wire logic src_valid,
   input wire logic src_ready,
   input wire logic [4:0] src_index,
   input wire logic [23:0] src_sample
);
   logic [4:0] exp_idx;
   logic run_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence acc_wait_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence stb_idle_s;
      sample_stb && run_q && !src_valid;
   endsequence
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         exp_idx <= 5'h00;
         run_q <= 1'b0;
      end else begin
         if (src_valid && src_ready) begin
            exp_idx <= src_index + 5'h01;
         end
         if (avs_write && !avs_waitrequest && avs_address == 10'h000) begin
            run_q <= avs_writedata[0];
         end
      end
   end
   wait_one_a: assert property (acc_wait_s |=> !avs_waitrequest)
      else $error("second wait cycle");
   wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait without request");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
      ((avs_address > 10'h008 && avs_address < 10'h100) || avs_address >= 10'h300) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   head_hold_a: assert property (src_valid && !src_ready |=> src_valid && $stable(src_index)
      && $stable(src_sample)) else $error("head word changed");
   index_step_a: assert property (src_valid |-> src_index == exp_idx)
      else $error("source order broken");
   full_scale_a: assert property (src_valid |-> src_sample != 24'h800000)
      else $error("sample beyond full scale");
   reset_empty_a: assert property ($rose(resetn) |-> !src_valid)
      else $error("stream not empty after reset");
   stb_word_a: assert property (stb_idle_s |-> ##[1:3] src_valid)
      else $error("strobe gave no word");
endmodule
bind atsb_bank atsb_bank_properties u_props (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .sample_stb, .src_valid, .src_ready, .src_index, .src_sample);
`default_nettype wire

//--- tb/atsb_sink.sv
`timescale 1ns/10ps
`default_nettype none
module atsb_sink (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic stall,
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [4:0] src_index,
   input wire logic [23:0] src_sample,
   input wire logic [31:0] channel_origin_tag
);
   logic [23:0] last [0:31];
   logic [31:0] tag [0:31];
   logic [4:0] route [0:15];
   logic [23:0] chan [0:15];
   int words;
   initial begin
      for (int c = 0; c < 16; c++) begin
         route[c] = 5'(c / 2);
      end
   end
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         src_ready <= 1'b0;
         words <= 0;
      end else begin
         src_ready <= !stall;
         if (src_valid && src_ready) begin
            last[src_index] <= src_sample;
            tag[src_index] <= channel_origin_tag;
            words <= words + 1;
         end
      end
   end
   always @* begin
      for (int c = 0; c < 16; c++) begin
         chan[c] = last[route[c]];
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic sample_stb = 1'b0;
   logic stall = 1'b0;
   logic src_valid, src_ready, avs_waitrequest;
   logic [31:0] avs_readdata, channel_origin_tag, rd;
   logic [4:0] src_index;
   logic [23:0] src_sample;
   int failures = 0;
   int total_checks = 0;
   always #10 ref_clk = ~ref_clk;
   atsb_bank #(.SAMPLE_RATE_HZ(18'd400)) u_dut (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .sample_stb, .src_valid,
      .src_ready, .src_index, .src_sample, .channel_origin_tag);
   atsb_sink u_sink (.ref_clk, .resetn, .stall, .src_valid, .src_ready, .src_index, .src_sample,
      .channel_origin_tag);
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         failures++;
         end_of_test();
      end
      @(posedge ref_clk);
   endtask
   task automatic await_words(input int target);
      int n;
      n = 0;
      while (u_sink.words < target && n < 600) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 600) begin
         failures++;
         end_of_test();
      end
      @(posedge ref_clk);
   endtask
   task automatic strobe;
      sample_stb <= 1'b1;
      @(posedge ref_clk);
      sample_stb <= 1'b0;
   endtask
   task automatic t_regs;
      bus(0, 10'h100, 0); chk(rd, 32'h07d0);
      bus(0, 10'h104, 0); chk(rd, 32'h14);
      bus(0, 10'h108, 0); chk(rd, 32'h20202020);
      bus(0, 10'h10c, 0); chk(rd, 0);
      bus(0, 10'h0fc, 0); chk(rd, 0);
      bus(1, 10'h110, 32'h1); bus(0, 10'h110, 0); chk(rd, 32'h14);
      bus(1, 10'h110, 32'hffff); bus(0, 10'h110, 0); chk(rd, 32'h9c40);
      bus(1, 10'h114, 32'h3f); bus(0, 10'h114, 0); chk(rd, 32'h3c);
      bus(0, 10'h2f0, 0); chk(rd, 32'h07d0);
   endtask
   task automatic t_tone;
      int s, a, c, m1, m2, r1, l1, r4, l4, n4;
      {m1, m2, r1, l1, r4, l4, n4} = '0;
      bus(1, 10'h110, 32'hc8); bus(1, 10'h114, 32'h0);
      bus(1, 10'h120, 32'hc8); bus(1, 10'h124, 32'h3c);
      bus(1, 10'h134, 32'h114);
      bus(1, 10'h140, 32'hc8); bus(1, 10'h144, 32'h200);
      bus(1, 10'h158, 32'h41424344); bus(1, 10'h000, 32'h1);
      for (int k = 0; k < 800; k++) begin
         strobe();
         await_words(32 * (k + 1));
         chk(u_sink.last[3], 0);
         s = $signed(u_sink.last[1]);
         if (k == 10) a = s;
         if (k == 11) c = s;
         if (k == 12) chk((a + s) < 32'sh2000 && (a + s) > -32'sh2000, 1);
         m1 = (s < 0 && -s > m1) ? -s : (s > m1 ? s : m1);
         r1 = (s == 0) ? r1 + 1 : 0;
         l1 = (r1 > l1) ? r1 : l1;
         s = $signed(u_sink.last[2]);
         m2 = (s < 0 && -s > m2) ? -s : (s > m2 ? s : m2);
         r4 = (u_sink.last[4] == 24'h0) ? r4 + 1 : 0;
         n4 = (r4 == 100) ? n4 + 1 : n4;
         l4 = (r4 > l4) ? r4 : l4;
      end
      chk((a < 0 ? -a : a) + (c < 0 ? -c : c) > 32'sh7f0000, 1);
      chk(m1 > 32'sh7f0000, 1);
      chk(m2 > 8300 && m2 < 8480, 1);
      chk(n4, 2);
      chk(l4 >= 100 && l4 <= 101, 1);
      chk(l1 <= 1, 1);
      chk(u_sink.tag[5], 32'h41424344);
      chk(u_sink.tag[0], 32'h20202020);
      chk(u_sink.chan[3], 32'h800001);
      chk(u_sink.chan[2], u_sink.chan[3]);
      bus(1, 10'h114, 32'h100);
      strobe();
      await_words(32 * 801);
      chk(u_sink.chan[2], 0);
      chk(u_sink.chan[3], 0);
   endtask
   task automatic t_fifo;
      int w;
      w = u_sink.words;
      stall <= 1'b1;
      repeat (2) @(posedge ref_clk);
      strobe();
      repeat (60) @(posedge ref_clk);
      bus(0, 10'h004, 0); chk(rd[12:0], 13'h1001);
      strobe();
      bus(0, 10'h004, 0); chk(rd[1:0], 2'h3);
      bus(1, 10'h004, 32'h2); bus(0, 10'h004, 0); chk(rd[1:0], 2'h1);
      stall <= 1'b0;
      await_words(w + 32);
      chk(u_sink.words, w + 32);
      bus(0, 10'h004, 0); chk(rd[12:0], 13'h0000);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_tone();
      t_fifo();
      end_of_test();
   end
endmodule
`default_nettype wire
